// ===== core/twpd_pkg.sv
package twpd_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_EVT_HZ = 10_000;
  localparam int MIN_EVT_CYC = CLK_HZ / MAX_EVT_HZ;
  localparam int TMR_W = 26;
  localparam logic [TMR_W-1:0] MIN_EVT_T = TMR_W'(MIN_EVT_CYC);

  // ----------------------------------------------------------------------
  // Event counts and thresholds (threshold unit is 0.1 V)
  // ----------------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_MIN = 10'h003;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h1f4;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] MISS_ONE = 10'h001;
  localparam logic [CNT_W-1:0] MISS_TWO = 10'h002;
  localparam int AMP_W = 8;
  localparam logic [AMP_W-1:0] TH_MIN = 8'h01;
  localparam logic [AMP_W-1:0] TH_MAX = 8'h4b;
  localparam logic [AMP_W-1:0] TH_HIGH = 8'h05;
  localparam logic [AMP_W-1:0] TH_MED = 8'h14;
  localparam logic [AMP_W-1:0] TH_LOW = 8'h32;

  // ----------------------------------------------------------------------
  // Interval ratios, written as numerator over denominator
  // ----------------------------------------------------------------------
  localparam logic [2:0] IDX_NUM = 3'h1;
  localparam logic [2:0] IDX_DEN = 3'h2;
  localparam logic [2:0] IDXX_NUM = 3'h3;
  localparam logic [2:0] IDXX_DEN = 3'h4;
  localparam logic [2:0] GAP1_NUM = 3'h3;
  localparam logic [2:0] GAP1_DEN = 3'h2;
  localparam logic [2:0] GAP2_NUM = 3'h5;
  localparam logic [2:0] GAP2_DEN = 3'h2;

  // ----------------------------------------------------------------------
  // Angle units: tenths of a degree per monitored rotation
  // ----------------------------------------------------------------------
  localparam logic [31:0] DEG_CRANK = 32'h0000_0e10;
  localparam logic [31:0] DEG_CAM = 32'h0000_1c20;
  localparam logic [15:0] OFFSET_RST = 16'h0258;

  // ----------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    TWPD_DISC_UNUSED = 4'b0000,
    TWPD_DISC_N      = 4'b0001,
    TWPD_DISC_NP1    = 4'b0010,
    TWPD_DISC_NP1X   = 4'b0011,
    TWPD_DISC_NM1    = 4'b0100,
    TWPD_DISC_NM2    = 4'b0101,
    TWPD_DISC_NMAG   = 4'b0110,
    TWPD_DISC_INDIV  = 4'b0111,
    TWPD_DISC_SINGLE = 4'b1000
  } twpd_disc_t;

  typedef enum logic [1:0] {
    TWPD_POL_PASSIVE  = 2'b00,
    TWPD_POL_ACT_LOW  = 2'b01,
    TWPD_POL_ACT_HIGH = 2'b10
  } twpd_pol_t;

  typedef enum logic [1:0] {
    TWPD_SENS_MANUAL = 2'b00,
    TWPD_SENS_HIGH   = 2'b01,
    TWPD_SENS_MED    = 2'b10,
    TWPD_SENS_LOW    = 2'b11
  } twpd_sens_t;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG0 = 8'h04;
  localparam logic [7:0] REG_CFG1 = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0c;
  localparam logic [7:0] REG_ADJUST = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_PERIOD = 8'h18;
  localparam logic [7:0] REG_POS = 8'h1c;
  localparam logic [7:0] REG_ANGLE = 8'h20;
  localparam logic [7:0] REG_REV = 8'h24;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SENS_LSB = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_CNT_LSB = 4;
  localparam int CFG_CAM_BIT = 16;
  localparam int CFG_POL_LSB = 17;
  localparam int CFG_TH_LSB = 20;
  localparam logic [31:0] CFG_MASK = 32'h0ff7_3fff;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam int ADJ_NOM_LSB = 16;
  localparam int ST_SYNC = 0;
  localparam int ST_DIR = 1;
  localparam int ST_CFG0 = 2;
  localparam int ST_CFG1 = 3;
  localparam int ST_FAST = 4;
  localparam int ST_TRIG1 = 5;
  localparam int ST_CAMIDX = 6;

endpackage

// ===== core/twpd_chan.sv
`timescale 1ns/100ps
module twpd_chan
(
  input wire logic clk,
  input wire logic rst,
  input wire logic active,
  input wire logic level,
  input wire logic [twpd_pkg::AMP_W-1:0] amp,
  input wire logic [1:0] pol,
  input wire logic [twpd_pkg::AMP_W-1:0] thresh,
  output logic evt,
  output logic [twpd_pkg::TMR_W-1:0] interval,
  output logic ival_ok,
  output logic fast
);
  import twpd_pkg::*;

  typedef struct packed {
    logic prev;
    logic armed;
    logic seen;
    logic [TMR_W-1:0] tmr;
    logic evt;
    logic [TMR_W-1:0] ival;
    logic ival_ok;
    logic fast;
  } twpd_chan_st_t;

  twpd_chan_st_t st_ff;
  twpd_chan_st_t nxt_st;
  logic on_lvl;
  logic lead;

  always_comb
  begin
    nxt_st = st_ff;
    // Passive pickups arrive as a zero-crossing level, rising on the event.
    on_lvl = (pol == TWPD_POL_ACT_LOW) ? ~level : level;
    lead = on_lvl & ~st_ff.prev;
    nxt_st.prev = on_lvl;
    nxt_st.evt = 1'b0;
    nxt_st.fast = 1'b0;
    if (st_ff.tmr != '1)
    begin
      nxt_st.tmr = st_ff.tmr + 1'b1;
    end
    if (lead)
    begin
      nxt_st.armed = 1'b1;
    end
    if (!on_lvl)
    begin
      nxt_st.armed = 1'b0;
    end
    // A pulse counts once, as soon as its amplitude reaches the threshold.
    if (active && on_lvl && (lead || st_ff.armed) && (amp >= thresh))
    begin
      nxt_st.armed = 1'b0;
      nxt_st.evt = 1'b1;
      nxt_st.ival = st_ff.tmr;
      nxt_st.ival_ok = st_ff.seen;
      nxt_st.seen = 1'b1;
      nxt_st.tmr = {{(TMR_W-1){1'b0}}, 1'b1};
      nxt_st.fast = st_ff.seen && (st_ff.tmr < MIN_EVT_T);
    end
    if (!active)
    begin
      nxt_st.armed = 1'b0;
      nxt_st.seen = 1'b0;
      nxt_st.ival_ok = 1'b0;
      nxt_st.evt = 1'b0;
      nxt_st.fast = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign evt = st_ff.evt;
  assign interval = st_ff.ival;
  assign ival_ok = st_ff.ival_ok;
  assign fast = st_ff.fast;

endmodule

// ===== core/twpd_cls.sv
`timescale 1ns/100ps
module twpd_cls
(
  input wire logic [twpd_pkg::TMR_W-1:0] iv,
  input wire logic [twpd_pkg::TMR_W-1:0] pv,
  output logic lt_idx,
  output logic lt_idxx,
  output logic gt_gap1,
  output logic gt_gap2
);
  import twpd_pkg::*;

  // Compares iv / pv against num / den without a divider.
  function automatic logic below(input logic [TMR_W-1:0] a, input logic [TMR_W-1:0] b,
                                 input logic [2:0] num, input logic [2:0] den);
    logic [TMR_W+2:0] lhs;
    logic [TMR_W+2:0] rhs;
    lhs = {3'h0, a} * {{TMR_W{1'b0}}, den};
    rhs = {3'h0, b} * {{TMR_W{1'b0}}, num};
    return lhs < rhs;
  endfunction

  function automatic logic above(input logic [TMR_W-1:0] a, input logic [TMR_W-1:0] b,
                                 input logic [2:0] num, input logic [2:0] den);
    logic [TMR_W+2:0] lhs;
    logic [TMR_W+2:0] rhs;
    lhs = {3'h0, a} * {{TMR_W{1'b0}}, den};
    rhs = {3'h0, b} * {{TMR_W{1'b0}}, num};
    return lhs > rhs;
  endfunction

  assign lt_idx = below(iv, pv, IDX_NUM, IDX_DEN);
  assign lt_idxx = below(iv, pv, IDXX_NUM, IDXX_DEN);
  // 1.5 sits midway between the 1x and 2x intervals, 2.5 between the 2x and 3x intervals that gaps produce.
  assign gt_gap1 = above(iv, pv, GAP1_NUM, GAP1_DEN);
  assign gt_gap2 = above(iv, pv, GAP2_NUM, GAP2_DEN);

endmodule

// ===== core/twpd_top.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module twpd_top
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] pu_level,
  input wire logic [twpd_pkg::AMP_W-1:0] pu_amp0,
  input wire logic [twpd_pkg::AMP_W-1:0] pu_amp1,
  output logic tooth_pulse,
  output logic index_pulse,
  output logic tdc_pulse,
  output logic sync,
  output logic dir_fault
);
  import twpd_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [1:0] sens;
    logic [1:0][31:0] cfg;
    logic [15:0] offset;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [CNT_W-1:0] pos;
    logic [TMR_W-1:0] pv;
    logic have_pv;
    logic idx_pend;
    logic [TMR_W-1:0] idx_iv;
    logic seen;
    logic sync;
    logic dir_err;
    logic fast_err;
    logic [31:0] acc;
    logic [27:0] rev_cnt;
    logic [27:0] rev;
    logic [TMR_W-1:0] period;
    logic tooth_p;
    logic index_p;
    logic tdc_p;
  } twpd_top_st_t;

  twpd_top_st_t st_ff;
  twpd_top_st_t nxt_st;

  // ----------------------------------------------------------------------
  // Per-channel configuration and pickup conditioning
  // ----------------------------------------------------------------------
  logic [1:0][AMP_W-1:0] amp_arr;
  logic [1:0][3:0] ch_type;
  logic [1:0][CNT_W-1:0] ch_n;
  logic [1:0] ch_cam;
  logic [1:0] ch_ok;
  logic [1:0] ch_trig;
  logic [1:0] ch_act;
  logic [1:0][AMP_W-1:0] ch_th;
  logic [1:0] ch_evt;
  logic [1:0][TMR_W-1:0] ch_iv;
  logic [1:0] ch_ivok;
  logic [1:0] ch_fast;

  assign amp_arr[0] = pu_amp0;
  assign amp_arr[1] = pu_amp1;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      logic [CNT_W-1:0] raw_n;
      logic [AMP_W-1:0] man_th;
      logic needs_n;
      logic [AMP_W-1:0] th;
      assign ch_type[gi] = st_ff.cfg[gi][CFG_TYPE_LSB +: 4];
      assign raw_n = st_ff.cfg[gi][CFG_CNT_LSB +: CNT_W];
      assign ch_cam[gi] = st_ff.cfg[gi][CFG_CAM_BIT];
      assign man_th = st_ff.cfg[gi][CFG_TH_LSB +: AMP_W];
      assign needs_n = (ch_type[gi] >= TWPD_DISC_N) && (ch_type[gi] <= TWPD_DISC_NMAG);
      // Counts the documented range rejects leave the input out of use.
      assign ch_ok[gi] = (ch_type[gi] != TWPD_DISC_UNUSED) && (ch_type[gi] <= TWPD_DISC_SINGLE)
                         && (!needs_n || ((raw_n >= CNT_MIN) && (raw_n <= CNT_MAX)));
      assign ch_n[gi] = (ch_type[gi] == TWPD_DISC_SINGLE) ? CNT_ONE : raw_n;
      assign ch_trig[gi] = ch_ok[gi] && (ch_type[gi] != TWPD_DISC_INDIV);
      assign ch_act[gi] = ch_ok[gi] && st_ff.en;
      always_comb
      begin
        case (twpd_sens_t'(st_ff.sens))
          TWPD_SENS_HIGH: th = TH_HIGH;
          TWPD_SENS_MED: th = TH_MED;
          TWPD_SENS_LOW: th = TH_LOW;
          default:
          begin
            if (man_th < TH_MIN)
            begin
              th = TH_MIN;
            end
            else if (man_th > TH_MAX)
            begin
              th = TH_MAX;
            end
            else
            begin
              th = man_th;
            end
          end
        endcase
      end
      // One driver for the shared threshold vector, one element per channel.
      assign ch_th[gi] = th;
      twpd_chan u_chan
      (
        .clk(clk),
        .rst(rst),
        .active(ch_act[gi]),
        .level(pu_level[gi]),
        .amp(amp_arr[gi]),
        .pol(st_ff.cfg[gi][CFG_POL_LSB +: 2]),
        .thresh(ch_th[gi]),
        .evt(ch_evt[gi]),
        .interval(ch_iv[gi]),
        .ival_ok(ch_ivok[gi]),
        .fast(ch_fast[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Input roles
  // ----------------------------------------------------------------------
  // With two trigger-capable inputs the finer disc drives the teeth and the
  // other one can only supply the phase reference.
  logic trig_sel;
  logic cam_sel;
  logic cam_idx;
  logic [3:0] tt;
  logic [CNT_W-1:0] tn;
  logic te;
  logic [TMR_W-1:0] iv;
  logic ivok;
  logic ce;
  logic lt_idx;
  logic lt_idxx;
  logic gt_gap1;
  logic gt_gap2;

  assign trig_sel = (ch_trig[0] && ch_trig[1]) ? (ch_n[1] > ch_n[0]) : (ch_trig[1] && !ch_trig[0]);
  assign cam_sel = ~trig_sel;
  assign cam_idx = ch_ok[cam_sel] && ch_trig[trig_sel] && (ch_n[cam_sel] == CNT_ONE
                   || ch_type[cam_sel] == TWPD_DISC_INDIV);
  assign tt = ch_type[trig_sel];
  assign tn = ch_n[trig_sel];
  assign te = ch_evt[trig_sel] && ch_trig[trig_sel];
  assign iv = ch_iv[trig_sel];
  assign ivok = ch_ivok[trig_sel];
  assign ce = ch_evt[cam_sel] && cam_idx;

  twpd_cls u_cls
  (
    .iv(iv),
    .pv(st_ff.pv),
    .lt_idx(lt_idx),
    .lt_idxx(lt_idxx),
    .gt_gap1(gt_gap1),
    .gt_gap2(gt_gap2)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic acc_ph;
  logic wr;
  logic first;
  logic tooth;
  logic upd_pv;
  logic [CNT_W-1:0] miss;
  logic [CNT_W-1:0] last_pos;
  logic [31:0] degr;
  logic [31:0] acc_new;
  logic signed [26:0] prod;
  logic [15:0] adj;
  logic [31:0] status;

  assign acc_ph = psel && penable;
  assign wr = acc_ph && st_ff.pready && pwrite && !st_ff.pslverr;
  assign degr = ch_cam[trig_sel] ? DEG_CAM : DEG_CRANK;
  assign prod = $signed(st_ff.offset) * $signed({1'b0, tn});
  assign adj = pwdata[15:0] - pwdata[ADJ_NOM_LSB +: 16];
  assign miss = (tt == TWPD_DISC_NM1) ? MISS_ONE : ((tt == TWPD_DISC_NM2) ? MISS_TWO : '0);
  assign last_pos = tn - CNT_ONE - miss;
  assign acc_new = st_ff.acc + degr;
  always_comb
  begin
    status = '0;
    status[ST_SYNC] = st_ff.sync;
    status[ST_DIR] = st_ff.dir_err;
    status[ST_CFG0] = (ch_type[0] != TWPD_DISC_UNUSED) && !ch_ok[0];
    status[ST_CFG1] = (ch_type[1] != TWPD_DISC_UNUSED) && !ch_ok[1];
    status[ST_FAST] = st_ff.fast_err;
    status[ST_TRIG1] = trig_sel;
    status[ST_CAMIDX] = cam_idx;
  end

  always_comb
  begin
    nxt_st = st_ff;
    first = 1'b0;
    tooth = 1'b0;
    upd_pv = 1'b0;
    nxt_st.tooth_p = 1'b0;
    nxt_st.index_p = 1'b0;
    nxt_st.tdc_p = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata = '0;
    if (acc_ph && !st_ff.pready)
    begin
      nxt_st.pready = 1'b1;
      case (paddr)
        REG_CTRL: nxt_st.prdata = {29'h0, st_ff.sens, st_ff.en};
        REG_CFG0: nxt_st.prdata = st_ff.cfg[0];
        REG_CFG1: nxt_st.prdata = st_ff.cfg[1];
        REG_OFFSET: nxt_st.prdata = {{16{st_ff.offset[15]}}, st_ff.offset};
        REG_ADJUST: nxt_st.prdata = '0;
        REG_STATUS: nxt_st.prdata = status;
        REG_PERIOD: nxt_st.prdata = {6'h0, st_ff.period};
        REG_POS: nxt_st.prdata = {22'h0, st_ff.pos};
        REG_ANGLE: nxt_st.prdata = st_ff.acc;
        REG_REV: nxt_st.prdata = {4'h0, st_ff.rev};
        default: nxt_st.pslverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        REG_CTRL:
        begin
          nxt_st.en = pwdata[CTRL_EN_BIT];
          nxt_st.sens = pwdata[CTRL_SENS_LSB +: 2];
        end
        REG_CFG0: nxt_st.cfg[0] = pwdata & CFG_MASK;
        REG_CFG1: nxt_st.cfg[1] = pwdata & CFG_MASK;
        REG_OFFSET: nxt_st.offset = pwdata[15:0];
        REG_ADJUST: nxt_st.offset = st_ff.offset + adj;
        REG_STATUS:
        begin
          nxt_st.dir_err = st_ff.dir_err & ~pwdata[ST_DIR];
          nxt_st.fast_err = st_ff.fast_err & ~pwdata[ST_FAST];
        end
        default: nxt_st.en = st_ff.en;
      endcase
    end
    // Hardware sets below override a clear written in the same cycle.
    if (ch_fast[0] || ch_fast[1])
    begin
      nxt_st.fast_err = 1'b1;
    end
    if (st_ff.rev_cnt != '1)
    begin
      nxt_st.rev_cnt = st_ff.rev_cnt + 1'b1;
    end
    if (ce)
    begin
      nxt_st.idx_pend = 1'b1;
    end
    if (!st_ff.en)
    begin
      nxt_st.sync = 1'b0;
      nxt_st.seen = 1'b0;
      nxt_st.pos = '0;
      nxt_st.have_pv = 1'b0;
      nxt_st.idx_pend = 1'b0;
    end
    else if (te)
    begin
      tooth = 1'b1;
      upd_pv = 1'b1;
      case (twpd_disc_t'(tt))
        TWPD_DISC_N:
        begin
          first = cam_idx ? st_ff.idx_pend : (!st_ff.seen || st_ff.pos == tn - CNT_ONE);
        end
        TWPD_DISC_NP1, TWPD_DISC_NP1X:
        begin
          if (st_ff.idx_pend)
          begin
            first = 1'b1;
            upd_pv = 1'b0;
            if (tt == TWPD_DISC_NP1 && iv < st_ff.idx_iv)
            begin
              nxt_st.dir_err = 1'b1;
            end
          end
          else if (ivok && st_ff.have_pv && ((tt == TWPD_DISC_NP1) ? lt_idx : lt_idxx))
          begin
            nxt_st.idx_pend = 1'b1;
            nxt_st.idx_iv = iv;
            tooth = 1'b0;
            upd_pv = 1'b0;
          end
        end
        TWPD_DISC_NM1, TWPD_DISC_NM2:
        begin
          if (ivok && st_ff.have_pv && ((tt == TWPD_DISC_NM1) ? gt_gap1 : gt_gap2))
          begin
            first = 1'b1;
            upd_pv = 1'b0;
          end
        end
        TWPD_DISC_NMAG: first = st_ff.idx_pend;
        TWPD_DISC_SINGLE: first = 1'b1;
        default:
        begin
          tooth = 1'b0;
          upd_pv = 1'b0;
        end
      endcase
      if (upd_pv && ivok)
      begin
        nxt_st.pv = iv;
        nxt_st.have_pv = 1'b1;
      end
      if (tooth)
      begin
        nxt_st.tooth_p = 1'b1;
        if (ivok)
        begin
          nxt_st.period = iv;
        end
        if (first)
        begin
          nxt_st.idx_pend = 1'b0;
          nxt_st.index_p = 1'b1;
          nxt_st.sync = st_ff.seen && (st_ff.pos == last_pos);
          nxt_st.seen = 1'b1;
          nxt_st.pos = '0;
          nxt_st.acc = 32'h0 - {{5{prod[26]}}, prod};
          nxt_st.tdc_p = (st_ff.offset == 16'h0000);
          nxt_st.rev = ch_cam[trig_sel] ? {1'b0, st_ff.rev_cnt[27:1]} : st_ff.rev_cnt;
          nxt_st.rev_cnt = '0;
        end
        else
        begin
          if (st_ff.pos != '1)
          begin
            nxt_st.pos = st_ff.pos + 1'b1;
          end
          if (st_ff.pos >= last_pos)
          begin
            nxt_st.sync = 1'b0;
          end
          nxt_st.acc = acc_new;
          if (st_ff.acc[31] && !acc_new[31])
          begin
            nxt_st.tdc_p = 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.en <= CTRL_RST[CTRL_EN_BIT];
      st_ff.sens <= CTRL_RST[CTRL_SENS_LSB +: 2];
      st_ff.cfg[0] <= CFG_RST;
      st_ff.cfg[1] <= CFG_RST;
      st_ff.offset <= OFFSET_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign tooth_pulse = st_ff.tooth_p;
  assign index_pulse = st_ff.index_p;
  assign tdc_pulse = st_ff.tdc_p;
  assign sync = st_ff.sync;
  assign dir_fault = st_ff.dir_err;

endmodule

// ===== dv/twpd_monitor.sv
`timescale 1ns/100ps
module twpd_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tooth_pulse,
  input wire logic index_pulse,
  input wire logic sync
);
  logic acc;
  logic bad;
  assign acc = psel && penable && !pready;
  assign bad = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ready_one_wait: assert property (acc |=> pready)
    else $error("pready late");
  a_ready_no_req: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_err_unmapped: assert property (acc && bad |=> pslverr)
    else $error("no error on bad address");
  a_err_mapped: assert property (acc && !bad |=> !pslverr)
    else $error("error on good address");
  a_tooth_spacing: assert property (tooth_pulse |=> !tooth_pulse [*2])
    else $error("tooth pulses too close");
  a_sync_at_index: assert property ($rose(sync) |-> index_pulse || $past(index_pulse))
    else $error("sync without index");
  c_err: cover property (pslverr);
  c_index: cover property (index_pulse);
  c_sync: cover property ($rose(sync));
endmodule
bind twpd_top twpd_monitor twpd_monitor_inst
(
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .tooth_pulse(tooth_pulse),
  .index_pulse(index_pulse),
  .sync(sync)
);

// ===== dv/twpd_pickup_model.sv
`timescale 1ns/100ps
module twpd_pickup_model
(
  input wire logic clk,
  input wire logic run,
  input wire logic [9:0] n,
  input wire logic [1:0] miss,
  input wire logic act_low,
  input wire logic [7:0] amp_set,
  output logic level,
  output logic [7:0] amp
);
  // One tooth every 2000 cycles keeps the input at the 10 kHz limit.
  localparam int PERIOD = 2000;
  int cyc = 0;
  logic [9:0] pos = 10'h0;
  logic pulse;
  always_ff @(posedge clk)
  begin
    if (!run || cyc == PERIOD - 1)
      cyc <= 0;
    else
      cyc <= cyc + 1;
    if (!run)
      pos <= 10'h0;
    else if (cyc == PERIOD - 1)
      pos <= (pos == n - 10'h1) ? 10'h0 : pos + 10'h1;
  end
  // Missing teeth sit at the end of the rotation.
  assign pulse = run && (cyc < 3) && (pos < n - 10'(miss));
  assign level = pulse ^ act_low;
  assign amp = pulse ? amp_set : 8'h0;
endmodule

// ===== dv/tooth_wheel_pickup_decoder_tb.sv
`timescale 1ns/100ps
module tooth_wheel_pickup_decoder_tb;
  import twpd_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} twpd_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire [1:0] pu_level;
  logic [7:0] amp0;
  logic [7:0] amp1;
  logic tooth_pulse;
  logic index_pulse;
  logic tdc_pulse;
  logic sync;
  logic dir_fault;
  logic run0 = 1'b0;
  logic low0 = 1'b0;
  logic [1:0] miss0 = 2'h0;
  logic [9:0] n0 = 10'h3;
  logic [7:0] a0 = 8'h20;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_tooth = 0;
  int n_index = 0;
  int n_tdc = 0;
  int i;
  twpd_row_t rows[8] = '{'{8'h00, 32'h4, 1'b0}, '{8'h04, 32'h0, 1'b0},
    '{8'h08, 32'h0, 1'b0}, '{8'h0c, 32'h258, 1'b0}, '{8'h10, 32'h0, 1'b0},
    '{8'h14, 32'h0, 1'b0}, '{8'h28, 32'h0, 1'b1}, '{8'h02, 32'h0, 1'b1}};
  int cnt[4] = '{2, 3, 500, 501};
  always #25 clk = ~clk;
  twpd_top twpd_top_inst
  (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pu_level(pu_level),
    .pu_amp0(amp0),
    .pu_amp1(amp1),
    .tooth_pulse(tooth_pulse),
    .index_pulse(index_pulse),
    .tdc_pulse(tdc_pulse),
    .sync(sync),
    .dir_fault(dir_fault)
  );
  twpd_pickup_model twpd_pickup_model_inst
  (
    .clk(clk),
    .run(run0),
    .n(n0),
    .miss(miss0),
    .act_low(low0),
    .amp_set(a0),
    .level(pu_level[0]),
    .amp(amp0)
  );
  // The second pickup pulses while its input is left unused.
  twpd_pickup_model twpd_pickup_model_inst2
  (
    .clk(clk),
    .run(run0),
    .n(10'h5),
    .miss(2'h0),
    .act_low(1'b0),
    .amp_set(8'h40),
    .level(pu_level[1]),
    .amp(amp1)
  );
  always @(posedge clk)
  begin
    if (tooth_pulse === 1'b1)
      n_tooth++;
    if (index_pulse === 1'b1)
      n_index++;
    if (tdc_pulse === 1'b1)
      n_tdc++;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    bit got;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    got = 1'b0;
    for (k = 0; k < 16 && !got; k++)
    begin
      @(posedge clk);
      got = (pready === 1'b1);
      rd = prdata;
      er = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!got)
    begin
      n_mismatch++;
      end_sim();
    end
    @(posedge clk);
  endtask
  task automatic cfg(input logic [31:0] ctrl, input logic [31:0] c0);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_CFG0, c0);
    apb(1'b1, REG_CTRL, ctrl);
  endtask
  task automatic spin(input int cyc);
    n_tooth = 0;
    n_index = 0;
    n_tdc = 0;
    run0 <= 1'b1;
    repeat (cyc) @(posedge clk);
    run0 <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("outs", 32'h0, {27'h0, tooth_pulse, index_pulse, tdc_pulse, sync, dir_fault});
    foreach (rows[j])
    begin
      apb(1'b0, rows[j].a, 32'h0);
      chk("reg", rows[j].d, rd);
      chk("err", {31'h0, rows[j].e}, {31'h0, er});
    end
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, REG_CFG0, (cnt[i] << 4) | 32'h1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("cfg_err", {31'h0, cnt[i] < 3 || cnt[i] > 500}, {31'h0, rd[ST_CFG0]});
    end
    apb(1'b1, REG_CFG0, 32'hffff_ffff);
    apb(1'b0, REG_CFG0, 32'h0);
    chk("cfg_mask", CFG_MASK, rd);
    apb(1'b1, REG_ADJUST, 32'h0032_0064);
    apb(1'b0, REG_OFFSET, 32'h0);
    chk("offset", 32'h28a, rd);
    cfg(32'h1, 32'h0104_0031);
    spin(12000);
    chk("teeth_n", 32'd6, n_tooth);
    a0 <= 8'h08;
    spin(6000);
    chk("teeth_low_amp", 32'd0, n_tooth);
    cfg(32'h3, 32'h0104_0031);
    spin(6000);
    chk("teeth_preset", 32'd3, n_tooth);
    low0 <= 1'b1;
    miss0 <= 2'h1;
    n0 <= 10'h4;
    a0 <= 8'h20;
    cfg(32'h1, 32'h0102_0044);
    spin(32000);
    chk("teeth_gap", 32'd12, n_tooth);
    chk("index_gap", 32'd3, n_index);
    // A positive offset puts one top dead center in every rotation after an index.
    chk("tdc", 32'd3, n_tdc);
    chk("sync", 32'h1, {31'h0, sync});
    end_sim();
  end
endmodule
